// ===== hdl/analog_input_pkg.sv
// shared constants and types for the first analog input control register
package analog_input_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ANALOG_INPUT_CONTROL_ONE_ADDR = 8'h02;
   localparam logic [7:0] ANALOG_INPUT_CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ****************************************
   // field layout
   // ****************************************
   localparam int PATH_SELECT_MSB = 7;
   localparam int PATH_SELECT_LSB = 6;
   localparam int SOURCE_MODE_MSB = 5;
   localparam int SOURCE_MODE_LSB = 0;
   localparam int CHROMA_GAIN_WIDTH = 9;

   // ****************************************
   // front-end path codes
   // ****************************************
   localparam logic [1:0] PATH_BYPASS_A = 2'h0;
   localparam logic [1:0] PATH_BYPASS_B = 2'h1;
   localparam logic [1:0] PATH_AMP_ONLY = 2'h2;
   localparam logic [1:0] PATH_AMP_FILTER = 2'h3;

   // ****************************************
   // source mode codes and pin numbering
   // ****************************************
   // pin index is {group - 1, line - 1}, so g3l2 is 4'h9
   localparam logic [5:0] MODE_LAST_SUPPORTED = 6'h1F;
   localparam logic [3:0] PIN_NONE = 4'h0;
   localparam logic [3:0] GROUP_PAIR_HIGH_OFFSET = 4'h8;
   localparam logic [3:0] CHROMA_GROUP_OFFSET = 4'h4;
   localparam logic [3:0] LUMA_HIGH_LINE_BASE = 4'h2;
   localparam logic [3:0] YC_PAIR_FIRST = 4'h6;
   localparam logic [3:0] YC_PAIR_LAST = 4'hD;
   localparam logic [3:0] YC_HIGH_LINE_FIRST = 4'hA;

   typedef enum logic [1:0] {
      CLASS_COMPOSITE,
      CLASS_LUMA_CHROMA,
      CLASS_UNSUPPORTED
   } source_class_t;

   typedef struct packed {
      source_class_t cls;
      logic [3:0] luma_pin;
      logic [3:0] chroma_pin;
      logic chroma_gain_slaved;
   } source_decode_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic amp_enable;
      logic aaf_enable;
      source_decode_t src;
      logic [CHROMA_GAIN_WIDTH-1:0] chroma_gain;
      logic [7:0] rdata;
      logic rd_valid;
      logic changed;
      logic bypass_advice;
   } control_state_t;

endpackage

// ===== hdl/source_mode_decoder.sv
// combinational decode of the six-bit analog source mode
`timescale 1ns/100ps
module source_mode_decoder (
   input wire logic [5:0] mode_in,
   output analog_input_pkg::source_decode_t decode_out
);

   logic [3:0] nib;
   logic [3:0] bank_offset;
   logic [3:0] luma_line;

   assign nib = mode_in[3:0];
   assign bank_offset = mode_in[4] ? analog_input_pkg::GROUP_PAIR_HIGH_OFFSET : 4'h0;
   assign luma_line = (nib >= analog_input_pkg::YC_HIGH_LINE_FIRST)
      ? analog_input_pkg::LUMA_HIGH_LINE_BASE + {3'h0, nib[0]}
      : {3'h0, nib[0]};

   always_comb begin
      decode_out = '{cls: analog_input_pkg::CLASS_UNSUPPORTED,
                     luma_pin: analog_input_pkg::PIN_NONE,
                     chroma_pin: analog_input_pkg::PIN_NONE,
                     chroma_gain_slaved: 1'b0};
      if (mode_in <= analog_input_pkg::MODE_LAST_SUPPORTED) begin
         if (nib >= analog_input_pkg::YC_PAIR_FIRST && nib <= analog_input_pkg::YC_PAIR_LAST) begin
            // luma and chroma share line, chroma sits one group up
            decode_out.cls = analog_input_pkg::CLASS_LUMA_CHROMA;  // see [R4] see [R6] see [R9]
            decode_out.luma_pin = bank_offset + luma_line;  // see [R11]
            decode_out.chroma_pin = bank_offset + luma_line
               + analog_input_pkg::CHROMA_GROUP_OFFSET;
            decode_out.chroma_gain_slaved = nib[3] & ~nib[1];  // see [R5] see [R7] see [R10] see [R12]
         end else begin
            decode_out.cls = analog_input_pkg::CLASS_COMPOSITE;
            unique case (mode_in)
               6'h00: decode_out.luma_pin = 4'h0;  // see [R3]
               6'h01: decode_out.luma_pin = 4'h1;
               6'h02: decode_out.luma_pin = 4'h4;
               6'h03: decode_out.luma_pin = 4'h5;
               6'h04: decode_out.luma_pin = 4'h6;
               6'h05: decode_out.luma_pin = 4'h7;
               6'h0E: decode_out.luma_pin = 4'h2;  // see [R8]
               6'h0F: decode_out.luma_pin = 4'h3;
               6'h10: decode_out.luma_pin = 4'h8;
               6'h11: decode_out.luma_pin = 4'h9;
               6'h12: decode_out.luma_pin = 4'hC;
               6'h13: decode_out.luma_pin = 4'hD;
               6'h14: decode_out.luma_pin = 4'hE;
               6'h15: decode_out.luma_pin = 4'hF;
               6'h1E: decode_out.luma_pin = 4'hA;  // see [R13]
               6'h1F: decode_out.luma_pin = 4'hB;
               default: decode_out.luma_pin = analog_input_pkg::PIN_NONE;
            endcase
         end
      end
   end

endmodule // source_mode_decoder

// ===== hdl/analog_input_mode_decode.sv
// first analog input control register with front-end and source decode
`timescale 1ns/100ps

// Contract
// [R1] register at 02h: path 7:6, mode 5:0
// [R2] path 00/01 bypass, 10 amp, 11 amp+filter
// [R3] modes 00-05 composite from six pins
// [R4] modes 06/07 Y g1, C g2 programmed
// [R5] modes 08/09 Y g1, C g2 slaved
// [R6] modes 0A/0B Y g1l3/4, C programmed
// [R7] modes 0C/0D Y g1l3/4, C slaved
// [R8] modes 0E-15 composite from eight pins
// [R9] modes 16/17 Y g3, C g4 programmed
// [R10] modes 18/19 Y g3, C g4 slaved
// [R11] modes 1A/1B Y g3l3/4, C programmed
// [R12] modes 1C/1D Y g3l3/4, C slaved
// [R13] modes 1E/1F composite from g3l3/g3l4
// [R14] programmed chroma gain from nine-bit field
// [R15] host should set luma bandwidth bypass
// [R16] host writes zero to unused bits
module analog_input_mode_decode (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic reg_wr_en_in,
   input wire logic reg_rd_en_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [8:0] chroma_gain_field_in,
   input wire logic luma_bandwidth_bypass_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rd_valid_out,
   output logic amp_enable_out,
   output logic aaf_enable_out,
   output logic composite_mode_out,
   output logic luma_chroma_mode_out,
   output logic mode_unsupported_out,
   output logic [3:0] luma_pin_out,
   output logic [3:0] chroma_pin_out,
   output logic chroma_gain_programmed_out,
   output logic chroma_gain_slaved_out,
   output logic [8:0] chroma_gain_out,
   output logic config_changed_out,
   output logic bypass_advice_out
);

   // ****************************************
   // state
   // ****************************************
   analog_input_pkg::control_state_t state_q;
   analog_input_pkg::control_state_t state_d;
   analog_input_pkg::source_decode_t src_next;
   logic wr_hit;
   logic rd_hit;
   logic [1:0] path_next;
   logic yc_next;
   logic prog_next;

   localparam analog_input_pkg::control_state_t STATE_RESET = '{
      ctrl: analog_input_pkg::ANALOG_INPUT_CONTROL_ONE_RESET,
      amp_enable: 1'b0,
      aaf_enable: 1'b0,
      src: '{cls: analog_input_pkg::CLASS_COMPOSITE,
             luma_pin: analog_input_pkg::PIN_NONE,
             chroma_pin: analog_input_pkg::PIN_NONE,
             chroma_gain_slaved: 1'b0},
      chroma_gain: 9'h000,
      rdata: analog_input_pkg::UNMAPPED_READ_VALUE,
      rd_valid: 1'b0,
      changed: 1'b0,
      bypass_advice: 1'b0
   };

   // ****************************************
   // address decode
   // ****************************************
   // other subaddresses belong to neighbouring blocks, so writes to them are ignored, but reads still answer UNMAPPED_READ_VALUE
   assign wr_hit = reg_wr_en_in
      && (reg_addr_in == analog_input_pkg::ANALOG_INPUT_CONTROL_ONE_ADDR);  // see [R1]
   assign rd_hit = reg_rd_en_in
      && (reg_addr_in == analog_input_pkg::ANALOG_INPUT_CONTROL_ONE_ADDR);

   // ****************************************
   // source mode decode
   // ****************************************
   // decoding the next value lets every output settle on the write edge
   source_mode_decoder u_source_mode_decoder (
      .mode_in (state_d.ctrl[analog_input_pkg::SOURCE_MODE_MSB:
                             analog_input_pkg::SOURCE_MODE_LSB]),
      .decode_out (src_next)
   );

   assign path_next = state_d.ctrl[analog_input_pkg::PATH_SELECT_MSB:
                                   analog_input_pkg::PATH_SELECT_LSB];
   assign yc_next = (src_next.cls == analog_input_pkg::CLASS_LUMA_CHROMA);
   assign prog_next = yc_next && !src_next.chroma_gain_slaved;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_d = state_q;

      // register write; all eight bits are live, so nothing is masked
      if (wr_hit) begin
         state_d.ctrl = reg_wdata_in;  // see [R1]
      end
      state_d.changed = wr_hit && (reg_wdata_in != state_q.ctrl);

      // front-end path
      unique case (path_next)
         analog_input_pkg::PATH_BYPASS_A: begin
            state_d.amp_enable = 1'b0;  // see [R2]
            state_d.aaf_enable = 1'b0;
         end
         analog_input_pkg::PATH_BYPASS_B: begin
            state_d.amp_enable = 1'b0;
            state_d.aaf_enable = 1'b0;
         end
         analog_input_pkg::PATH_AMP_ONLY: begin
            state_d.amp_enable = 1'b1;
            state_d.aaf_enable = 1'b0;
         end
         analog_input_pkg::PATH_AMP_FILTER: begin
            state_d.amp_enable = 1'b1;
            state_d.aaf_enable = 1'b1;
         end
      endcase

      // source routing
      state_d.src = src_next;  // see [R3] see [R8] see [R13]

      // chroma gain only passes in programmed luma/chroma modes, else held at zero
      if (prog_next) begin
         state_d.chroma_gain = chroma_gain_field_in;  // see [R14]
      end else begin
         state_d.chroma_gain = 9'h000;
      end

      // flag a separate luma/chroma setup left at reduced luma bandwidth
      state_d.bypass_advice = yc_next && !luma_bandwidth_bypass_in;  // see [R15]

      // read answer: the stored value before any write in the same cycle
      state_d.rd_valid = reg_rd_en_in;
      if (rd_hit) begin
         state_d.rdata = state_q.ctrl;
      end else if (reg_rd_en_in) begin
         state_d.rdata = analog_input_pkg::UNMAPPED_READ_VALUE;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata_out = state_q.rdata;
   assign reg_rd_valid_out = state_q.rd_valid;
   assign amp_enable_out = state_q.amp_enable;
   assign aaf_enable_out = state_q.aaf_enable;
   assign composite_mode_out =
      (state_q.src.cls == analog_input_pkg::CLASS_COMPOSITE);
   assign luma_chroma_mode_out =
      (state_q.src.cls == analog_input_pkg::CLASS_LUMA_CHROMA);
   assign mode_unsupported_out =
      (state_q.src.cls == analog_input_pkg::CLASS_UNSUPPORTED);
   assign luma_pin_out = state_q.src.luma_pin;
   assign chroma_pin_out = state_q.src.chroma_pin;
   assign chroma_gain_programmed_out = (state_q.src.cls
      == analog_input_pkg::CLASS_LUMA_CHROMA) && !state_q.src.chroma_gain_slaved;
   assign chroma_gain_slaved_out = state_q.src.chroma_gain_slaved;
   assign chroma_gain_out = state_q.chroma_gain;
   assign config_changed_out = state_q.changed;
   assign bypass_advice_out = state_q.bypass_advice;

endmodule // analog_input_mode_decode

// ===== testbench/analog_input_mode_decode_sva.sv
// port assertions for the analog input mode decode
`timescale 1ns/100ps
module analog_input_mode_decode_sva (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic reg_wr_en_in,
   input wire logic reg_rd_en_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [8:0] chroma_gain_field_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rd_valid_out,
   input wire logic amp_enable_out,
   input wire logic aaf_enable_out,
   input wire logic composite_mode_out,
   input wire logic luma_chroma_mode_out,
   input wire logic mode_unsupported_out,
   input wire logic [3:0] luma_pin_out,
   input wire logic [3:0] chroma_pin_out,
   input wire logic chroma_gain_programmed_out,
   input wire logic chroma_gain_slaved_out,
   input wire logic [8:0] chroma_gain_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire wr2 = reg_wr_en_in && reg_addr_in == analog_input_pkg::ANALOG_INPUT_CONTROL_ONE_ADDR;
   wire rd2 = reg_rd_en_in && reg_addr_in == analog_input_pkg::ANALOG_INPUT_CONTROL_ONE_ADDR;
   chk_amp_path: assert property (wr2 |=> amp_enable_out == $past(reg_wdata_in[7]))
      else $error("amplifier enable wrong");
   chk_filter_path: assert property (wr2 |=> aaf_enable_out == &$past(reg_wdata_in[7:6]))
      else $error("filter enable wrong");
   chk_read_back: assert property (wr2 ##1 rd2 |=> reg_rd_valid_out && reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("read back wrong");
   chk_unmapped_read: assert property (reg_rd_en_in && !rd2 |=> reg_rd_valid_out && reg_rdata_out == 8'h00)
      else $error("unmapped read wrong");
   chk_decode_held: assert property (!wr2 |=> $stable(luma_pin_out) && $stable(chroma_pin_out) && $stable(luma_chroma_mode_out))
      else $error("decode changed without write");
   chk_yc_pair: assert property (luma_chroma_mode_out |-> chroma_pin_out == luma_pin_out + 4'h4)
      else $error("chroma pin not paired");
   chk_composite_alone: assert property (composite_mode_out |-> chroma_pin_out == 4'h0 && !chroma_gain_programmed_out && !chroma_gain_slaved_out)
      else $error("composite mode drives chroma");
   chk_gain_source: assert property (chroma_gain_programmed_out |-> chroma_gain_out == $past(chroma_gain_field_in))
      else $error("chroma gain not from field");
   chk_gain_kind: assert property (chroma_gain_programmed_out |-> luma_chroma_mode_out && !chroma_gain_slaved_out)
      else $error("gain kind conflict");
   chk_mode_range: assert property (wr2 |=> mode_unsupported_out == $past(reg_wdata_in[5]))
      else $error("unsupported flag wrong");
   cover property (wr2 ##1 luma_chroma_mode_out);
   cover property (chroma_gain_slaved_out);
   cover property (reg_rd_en_in && !rd2);
endmodule // analog_input_mode_decode_sva
bind analog_input_mode_decode analog_input_mode_decode_sva chk (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .chroma_gain_out(chroma_gain_out),
   .chroma_gain_field_in(chroma_gain_field_in), .reg_rdata_out(reg_rdata_out),
   .reg_rd_valid_out(reg_rd_valid_out), .amp_enable_out(amp_enable_out),
   .aaf_enable_out(aaf_enable_out), .composite_mode_out(composite_mode_out),
   .luma_chroma_mode_out(luma_chroma_mode_out), .mode_unsupported_out(mode_unsupported_out),
   .luma_pin_out(luma_pin_out), .chroma_pin_out(chroma_pin_out),
   .chroma_gain_programmed_out(chroma_gain_programmed_out),
   .chroma_gain_slaved_out(chroma_gain_slaved_out));

// ===== testbench/host_model.sv
// host model that drives the register strobe port
`timescale 1ns/100ps
module host_model (
   input wire logic core_clk_in,
   output logic wr_out = 1'b0,
   output logic rd_out = 1'b0,
   output logic [7:0] addr_out = 8'h00,
   output logic [7:0] wdata_out = 8'h00,
   output logic byp_out = 1'b0
);
   // all eight bits are fields, so no unused bit is left to clear
   task automatic put(input logic [7:0] a, input logic [7:0] d, input logic b);
      @(posedge core_clk_in) #1;
      byp_out = b; // caller decides whether bandwidth advice is followed
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(posedge core_clk_in) #1;
      wr_out = 1'b0;
      wdata_out = ~d;
   endtask
   // no leading wait, so a read lands right after a write
   task automatic get(input logic [7:0] a);
      rd_out = 1'b1;
      addr_out = a;
      @(posedge core_clk_in) #1;
      rd_out = 1'b0;
   endtask
endmodule // host_model

// ===== testbench/testbench.sv
// self-checking bench for the analog input mode decode
`timescale 1ns/100ps
module testbench;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [8:0] fld = 9'h000;
   logic wr, rd, byp, rv, amp, aaf, comp, yc, uns, prog, slv, chg, adv;
   logic [7:0] addr, wd, rdata, v, prev;
   logic [3:0] lp, cp;
   logic [8:0] gain;
   int fail_count = 0;
   int n_compared = 0;
   // luma or composite pin per mode, mode 0 in the low nibble
   logic [127:0] luma_tab = 128'hBABABA9898FEDC98_3232321010765410;
   always #2.5 core_clk_in = ~core_clk_in;
   host_model host (.core_clk_in(core_clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
      .wdata_out(wd), .byp_out(byp));
   analog_input_mode_decode DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
      .chroma_gain_field_in(fld), .luma_bandwidth_bypass_in(byp), .reg_rdata_out(rdata),
      .reg_rd_valid_out(rv), .amp_enable_out(amp), .aaf_enable_out(aaf),
      .composite_mode_out(comp), .luma_chroma_mode_out(yc), .mode_unsupported_out(uns),
      .luma_pin_out(lp), .chroma_pin_out(cp), .chroma_gain_programmed_out(prog),
      .chroma_gain_slaved_out(slv), .chroma_gain_out(gain), .config_changed_out(chg),
      .bypass_advice_out(adv));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic expect_mode(input logic [7:0] x);
      logic [5:0] m;
      logic y;
      logic [3:0] l;
      m = x[5:0];
      y = !m[5] && m[3:0] >= 4'h6 && m[3:0] <= 4'hD;
      l = m[5] ? 4'h0 : luma_tab[m * 4 +: 4];
      check("decode", {amp, aaf, comp, yc, uns, prog, slv, adv, lp, cp}, {x[7], &x[7:6],
         !m[5] && !y, y, m[5], y && m[1], y && !m[1], y && !byp, l, y ? l + 4'h4 : 4'h0});
      check("gain", gain, (y && m[1]) ? fld : 9'h000);
   endtask
   initial begin
      #20us;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(45));
      prev = 8'h00;
      repeat (3) @(posedge core_clk_in);
      #1 sys_rst_in = 1'b0;
      @(posedge core_clk_in) #1;
      expect_mode(8'h00);
      for (int i = 0; i < 64; i++) begin
         v = {i[1:0], i[5:0]};
         fld = 9'($urandom);
         host.put(8'h02, v, 1'($urandom));
         check("changed", chg, v != prev);
         expect_mode(v);
         host.get(8'h02);
         check("rdata", {rv, rdata}, {1'b1, v});
         prev = v;
      end
      host.put(8'h02, v, byp);
      check("changed", chg, 1'b0);
      host.put(8'h03, 8'h86, byp);
      expect_mode(v);
      host.get(8'h03);
      check("unmapped", {rv, rdata}, {1'b1, 8'h00});
      tally_and_finish();
   end
endmodule // testbench
